/* fm_pkg.sv */
package fm_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_MAIN_CONTROL = 8'h00;
    localparam logic [7:0] IDX_MEASURE_TRIGGER = 8'h01;
    localparam logic [7:0] IDX_WINDOW_CONFIG = 8'h02;
    localparam logic [7:0] IDX_IRQ_ENABLE_CLEAR = 8'h08;
    localparam logic [7:0] IDX_IRQ_ENABLE_SET = 8'h09;
    localparam logic [7:0] IDX_IRQ_FLAGS = 8'h0a;
    localparam logic [7:0] IDX_METER_STATE = 8'h0b;
    localparam logic [7:0] IDX_SYNC_PENDING = 8'h0c;
    localparam logic [7:0] IDX_COUNT_RESULT = 8'h10;
    localparam int ADDR_W = 8;

    ////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int BIT_SOFT_RESET = 0;
    localparam int BIT_ENABLE = 1;
    localparam int BIT_START = 0;
    localparam int BIT_DONE = 0;
    localparam int BIT_BUSY = 0;
    localparam int BIT_OVERFLOW = 1;
    localparam int BIT_SYNC_SOFT_RESET_BIT = 0;
    localparam int BIT_SYNC_ENABLE = 1;
    localparam int REFERENCE_CYCLE_COUNT_W = 8;
    localparam int RESULT_W = 24;

    ////////////////////////////////////////////////////////////////////////////
    // reset values and timing
    localparam logic [REFERENCE_CYCLE_COUNT_W-1:0] REFERENCE_CYCLE_COUNT_RESET = 8'h00;
    localparam logic [RESULT_W-1:0] RESULT_RESET = 24'h000000;
    localparam logic [RESULT_W-1:0] RESULT_MAX = 24'hffffff;
    localparam logic [1:0] SYNC_CYCLES = 2'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [31:0] READ_ZERO = 32'h00000000;

    ////////////////////////////////////////////////////////////////////////////
    // axi4-lite channels bundled
    typedef struct packed {
        logic awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [ADDR_W-1:0] araddr;
        logic rready;
    } fm_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } fm_axi_rsp_t;

    typedef enum logic [1:0] {
        MS_IDLE,
        MS_ARM,
        MS_COUNT
    } fm_meas_state_t;

endpackage : fm_pkg

/* fm_frequency_meter.sv */
// What this block does
// - count measured clock periods over programmed reference cycles into a 24-bit result
// - window config accepts writes only while enable reads zero
// - enable bit 1 of main control enables, zero disables the meter
// - soft reset one resets every register and disables; zero does nothing
// - soft reset write discards every other field of that access
// - enable and soft reset pass a synchronizer with pending bits software polls
// - soft reset bit reads one while the reset is ongoing
// - start bit write of one begins a measurement once enabled
// - busy rises when a measurement begins and falls when it completes
// - completion sets done flag; irq while flag and enable both set
// - irq enable set and clear registers, ones act, zeros ignored
// - irq stays until flag cleared, enable cleared or meter reset
// - meter runs in idle sleep; done irq can wake the device
// - software checks sticky overflow, adjusts, clears with one, restarts
// - reading start register under access protection gives an error
// - done flag set on busy falling; write one clears, zero keeps
// - sticky overflow sets on result counter overflow until written one
`timescale 1ns/10ps
`default_nettype none

module fm_frequency_meter (
    input wire logic mclk,
    input wire logic reset,
    input wire fm_pkg::fm_axi_req_t axiReq,
    output fm_pkg::fm_axi_rsp_t axiRsp,
    input wire logic measuredClock,
    input wire logic referenceClock,
    input wire logic accessProtect,
    output logic irqReq
);
    import fm_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // helpers
    // a change counts once second and third stage agree
    function automatic logic riseSeen(input logic [2:0] chain, input logic level);
        riseSeen = (chain[1] == chain[2]) && chain[2] && !level;
    endfunction : riseSeen
    function automatic logic [ADDR_W-1:0] byteAddr(input logic [7:0] idx);
        byteAddr = ADDR_W'({idx[5:0], 2'b00});
    endfunction : byteAddr

    ////////////////////////////////////////////////////////////////////////////
    // declarations
    logic awHeld_q, wHeld_q, bValid_q, rValid_q, awTake, wTake, arTake, writeFire, lowLane, protectedWrite;
    logic [ADDR_W-1:0] awAddr_q;
    logic [31:0] wData_q, rData_q, readWord;
    logic [3:0] wStrb_q;
    logic [1:0] bResp_q, rResp_q, enSync_q, rstSync_q;
    logic readErr, wrMain, wrTrigger, wrWindow, wrIenClr, wrIenSet, wrFlags, wrState;
    logic enableReq_q, enableEff_q, swrstPend_q, swrstDone, irqEnable_q, doneFlag_q, overflow_q;
    logic busy, busy_q, startReq, msrLevel_q, refLevel_q, msrRise, refRise;
    logic [REFERENCE_CYCLE_COUNT_W-1:0] reference_cycle_count_q, refCount_q;
    logic [RESULT_W-1:0] result_q;
    logic [2:0] msrSync_q, refSync_q;
    fm_meas_state_t measState_q;

    ////////////////////////////////////////////////////////////////////////////
    // bus handshake
    assign awTake = axiReq.awvalid && axiRsp.awready;
    assign wTake = axiReq.wvalid && axiRsp.wready;
    assign arTake = axiReq.arvalid && axiRsp.arready;
    assign writeFire = awHeld_q && wHeld_q && !bValid_q;

    always_comb begin
        axiRsp.awready = !awHeld_q && !bValid_q;
        axiRsp.wready = !wHeld_q && !bValid_q;
        axiRsp.bvalid = bValid_q;
        axiRsp.bresp = bResp_q;
        axiRsp.arready = !rValid_q;
        axiRsp.rvalid = rValid_q;
        axiRsp.rdata = rData_q;
        axiRsp.rresp = rResp_q;
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            awHeld_q <= 1'b0;
            awAddr_q <= '0;
        end else if (awTake) begin
            awHeld_q <= 1'b1;
            awAddr_q <= axiReq.awaddr;
        end else if (writeFire) begin
            awHeld_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            wHeld_q <= 1'b0;
            wData_q <= '0;
            wStrb_q <= '0;
        end else if (wTake) begin
            wHeld_q <= 1'b1;
            wData_q <= axiReq.wdata;
            wStrb_q <= axiReq.wstrb;
        end else if (writeFire) begin
            wHeld_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            bValid_q <= 1'b0;
            bResp_q <= RESP_OKAY;
        end else if (writeFire) begin
            bValid_q <= 1'b1;
            bResp_q <= protectedWrite ? RESP_SLVERR : RESP_OKAY;
        end else if (axiReq.bready) begin
            bValid_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // write decode; only the low byte lane carries fields
    assign lowLane = wStrb_q[0];
    assign protectedWrite = accessProtect && (awAddr_q == byteAddr(IDX_MAIN_CONTROL)
        || awAddr_q == byteAddr(IDX_WINDOW_CONFIG) || awAddr_q == byteAddr(IDX_IRQ_ENABLE_CLEAR)
        || awAddr_q == byteAddr(IDX_IRQ_ENABLE_SET));

    always_comb begin
        wrMain = 1'b0;
        wrTrigger = 1'b0;
        wrWindow = 1'b0;
        wrIenClr = 1'b0;
        wrIenSet = 1'b0;
        wrFlags = 1'b0;
        wrState = 1'b0;
        if (writeFire && lowLane && !protectedWrite && !swrstPend_q) begin
            case (awAddr_q)
                byteAddr(IDX_MAIN_CONTROL): wrMain = 1'b1;
                byteAddr(IDX_MEASURE_TRIGGER): wrTrigger = 1'b1;
                byteAddr(IDX_WINDOW_CONFIG): wrWindow = 1'b1;
                byteAddr(IDX_IRQ_ENABLE_CLEAR): wrIenClr = 1'b1;
                byteAddr(IDX_IRQ_ENABLE_SET): wrIenSet = 1'b1;
                byteAddr(IDX_IRQ_FLAGS): wrFlags = 1'b1;
                byteAddr(IDX_METER_STATE): wrState = 1'b1;
                default: wrMain = 1'b0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read path
    always_comb begin
        readWord = READ_ZERO;
        readErr = 1'b0;
        case (axiReq.araddr)
            byteAddr(IDX_MAIN_CONTROL): begin
                readWord[BIT_ENABLE] = enableReq_q;
                readWord[BIT_SOFT_RESET] = swrstPend_q;
            end
            byteAddr(IDX_MEASURE_TRIGGER): readErr = accessProtect;
            byteAddr(IDX_WINDOW_CONFIG): readWord[REFERENCE_CYCLE_COUNT_W-1:0] = reference_cycle_count_q;
            byteAddr(IDX_IRQ_ENABLE_CLEAR): readWord[BIT_DONE] = irqEnable_q;
            byteAddr(IDX_IRQ_ENABLE_SET): readWord[BIT_DONE] = irqEnable_q;
            byteAddr(IDX_IRQ_FLAGS): readWord[BIT_DONE] = doneFlag_q;
            byteAddr(IDX_METER_STATE): begin
                readWord[BIT_OVERFLOW] = overflow_q;
                readWord[BIT_BUSY] = busy_q;
            end
            byteAddr(IDX_SYNC_PENDING): begin
                readWord[BIT_SYNC_ENABLE] = (enSync_q != 2'h0);
                readWord[BIT_SYNC_SOFT_RESET_BIT] = swrstPend_q;
            end
            byteAddr(IDX_COUNT_RESULT): readWord[RESULT_W-1:0] = result_q;
            default: readWord = READ_ZERO;
        endcase
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            rValid_q <= 1'b0;
            rData_q <= READ_ZERO;
            rResp_q <= RESP_OKAY;
        end else if (arTake) begin
            rValid_q <= 1'b1;
            rData_q <= readErr ? READ_ZERO : readWord;
            rResp_q <= readErr ? RESP_SLVERR : RESP_OKAY;
        end else if (axiReq.rready) begin
            rValid_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // soft reset with synchronisation delay
    assign swrstDone = swrstPend_q && (rstSync_q == 2'h0);

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            swrstPend_q <= 1'b0;
            rstSync_q <= 2'h0;
        end else if (wrMain && wData_q[BIT_SOFT_RESET]) begin
            swrstPend_q <= 1'b1;
            rstSync_q <= SYNC_CYCLES;
        end else if (swrstDone) begin
            swrstPend_q <= 1'b0;
        end else if (rstSync_q != 2'h0) begin
            rstSync_q <= rstSync_q - 2'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // enable with synchronisation delay
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            enableReq_q <= 1'b0;
            enableEff_q <= 1'b0;
            enSync_q <= 2'h0;
        end else if (swrstDone) begin
            enableReq_q <= 1'b0;
            enableEff_q <= 1'b0;
            enSync_q <= 2'h0;
        end else if (wrMain && !wData_q[BIT_SOFT_RESET]) begin
            enableReq_q <= wData_q[BIT_ENABLE];
            enSync_q <= SYNC_CYCLES;
        end else if (enSync_q == 2'h1) begin
            enableEff_q <= enableReq_q;
            enSync_q <= 2'h0;
        end else if (enSync_q != 2'h0) begin
            enSync_q <= enSync_q - 2'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // window configuration
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            reference_cycle_count_q <= REFERENCE_CYCLE_COUNT_RESET;
        end else if (swrstDone) begin
            reference_cycle_count_q <= REFERENCE_CYCLE_COUNT_RESET;
        end else if (wrWindow && !enableReq_q) begin
            reference_cycle_count_q <= wData_q[REFERENCE_CYCLE_COUNT_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // clock input sampling
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            msrSync_q <= 3'h0;
            refSync_q <= 3'h0;
            msrLevel_q <= 1'b0;
            refLevel_q <= 1'b0;
        end else begin
            msrSync_q <= {msrSync_q[1:0], measuredClock};
            refSync_q <= {refSync_q[1:0], referenceClock};
            if (msrSync_q[1] == msrSync_q[2]) begin
                msrLevel_q <= msrSync_q[2];
            end
            if (refSync_q[1] == refSync_q[2]) begin
                refLevel_q <= refSync_q[2];
            end
        end
    end

    assign msrRise = riseSeen(msrSync_q, msrLevel_q);
    assign refRise = riseSeen(refSync_q, refLevel_q);

    ////////////////////////////////////////////////////////////////////////////
    // measurement sequencer
    assign startReq = wrTrigger && wData_q[BIT_START] && enableEff_q;
    assign busy = (measState_q != MS_IDLE);

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            measState_q <= MS_IDLE;
            refCount_q <= '0;
        end else if (swrstDone || !enableEff_q) begin
            measState_q <= MS_IDLE;
            refCount_q <= '0;
        end else begin
            case (measState_q)
                MS_IDLE: begin
                    if (startReq) begin
                        measState_q <= MS_ARM;
                    end
                end
                MS_ARM: begin
                    if (refRise) begin
                        measState_q <= MS_COUNT;
                        refCount_q <= '0;
                    end
                end
                MS_COUNT: begin
                    if (refRise) begin
                        if (refCount_q + 8'h01 >= reference_cycle_count_q) begin
                            measState_q <= MS_IDLE;
                        end else begin
                            refCount_q <= refCount_q + 8'h01;
                        end
                    end
                end
                default: measState_q <= MS_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= busy && !swrstDone;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // result counter and sticky overflow
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            result_q <= RESULT_RESET;
        end else if (swrstDone) begin
            result_q <= RESULT_RESET;
        end else if (startReq && !busy) begin
            result_q <= RESULT_RESET;
        end else if (measState_q == MS_COUNT && msrRise) begin
            result_q <= result_q + 24'h000001;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            overflow_q <= 1'b0;
        end else if (swrstDone) begin
            overflow_q <= 1'b0;
        end else if (measState_q == MS_COUNT && msrRise && result_q == RESULT_MAX) begin
            overflow_q <= 1'b1;
        end else if (wrState && wData_q[BIT_OVERFLOW]) begin
            overflow_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // done flag, irq enable and request
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            doneFlag_q <= 1'b0;
        end else if (swrstDone) begin
            doneFlag_q <= 1'b0;
        end else if (busy_q && !busy) begin
            doneFlag_q <= 1'b1;
        end else if (wrFlags && wData_q[BIT_DONE]) begin
            doneFlag_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            irqEnable_q <= 1'b0;
        end else if (swrstDone) begin
            irqEnable_q <= 1'b0;
        end else if (wrIenSet && wData_q[BIT_DONE]) begin
            irqEnable_q <= 1'b1;
        end else if (wrIenClr && wData_q[BIT_DONE]) begin
            irqEnable_q <= 1'b0;
        end
    end

    // plain level on mclk, also serves as idle-sleep wake request
    assign irqReq = doneFlag_q && irqEnable_q;

endmodule : fm_frequency_meter

`default_nettype wire

/* fm_checker_properties.sv */
`timescale 1ns/10ps
`default_nettype none

module fm_checker (
    input wire logic mclk,
    input wire logic reset,
    input wire fm_pkg::fm_axi_req_t axiReq,
    input wire fm_pkg::fm_axi_rsp_t axiRsp,
    input wire logic measuredClock,
    input wire logic referenceClock,
    input wire logic accessProtect,
    input wire logic irqReq
);
    import fm_pkg::*;
    ////////////////////////////////////////////////////////////
    logic wrTake;
    logic arTake;
    assign wrTake = axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready;
    assign arTake = axiReq.arvalid && axiRsp.arready;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////
    a_bresp_held: assert property (axiRsp.bvalid && !axiReq.bready |=> axiRsp.bvalid && $stable(axiRsp.bresp))
        else $error("write response dropped early");
    a_rdata_held: assert property (axiRsp.rvalid && !axiReq.rready
        |=> axiRsp.rvalid && $stable(axiRsp.rdata) && $stable(axiRsp.rresp))
        else $error("read response dropped early");
    a_write_refused: assert property (axiRsp.bvalid |-> !axiRsp.awready && !axiRsp.wready)
        else $error("write taken while response pending");
    a_read_refused: assert property (axiRsp.rvalid |-> !axiRsp.arready)
        else $error("read taken while response pending");
    a_write_latency: assert property (wrTake |=> !axiRsp.bvalid ##1 axiRsp.bvalid)
        else $error("write response not one cycle after apply");
    a_read_latency: assert property (arTake |=> axiRsp.rvalid)
        else $error("read response late");
    a_protect_read: assert property (
        arTake && axiReq.araddr == {IDX_MEASURE_TRIGGER[5:0], 2'b00} && accessProtect
        |=> axiRsp.rresp == RESP_SLVERR && axiRsp.rdata == READ_ZERO)
        else $error("protected trigger read not refused");
    a_result_width: assert property (
        arTake && axiReq.araddr == {IDX_COUNT_RESULT[5:0], 2'b00} |=> axiRsp.rdata[31:24] == 8'h00)
        else $error("result wider than 24 bits");
    a_reserved_zero: assert property (arTake && axiReq.araddr > 8'h08 && axiReq.araddr < 8'h20
        |=> axiRsp.rdata == READ_ZERO && axiRsp.rresp == RESP_OKAY)
        else $error("reserved read not zero");
    a_irq_masked: assert property (
        wrTake && axiReq.awaddr == {IDX_IRQ_ENABLE_CLEAR[5:0], 2'b00} && axiReq.wdata[0]
        && axiReq.wstrb[0] && !accessProtect |=> ##1 !irqReq)
        else $error("irq still high after enable clear");
    a_soft_reset_bit_irq: assert property (
        wrTake && axiReq.awaddr == {IDX_MAIN_CONTROL[5:0], 2'b00} && axiReq.wdata[0]
        && axiReq.wstrb[0] && !accessProtect |=> ##[1:12] !irqReq)
        else $error("irq survives soft reset");
endmodule : fm_checker

bind fm_frequency_meter fm_checker fm_checker_i (.mclk(mclk), .reset(reset), .axiReq(axiReq), .axiRsp(axiRsp),
    .measuredClock(measuredClock), .referenceClock(referenceClock), .accessProtect(accessProtect), .irqReq(irqReq));

`default_nettype wire

/* testbench.sv */
`timescale 1ns/10ps
`default_nettype none

module testbench;
    import fm_pkg::*;
    logic mclk;
    logic reset;
    fm_axi_req_t axiReq;
    fm_axi_rsp_t axiRsp;
    logic measuredClock;
    logic referenceClock;
    logic accessProtect;
    logic irqReq;
    int mismatches;
    int comparisons;
    int seed;
    int phaseCnt;
    int refMult;
    int reference_cycle_count;
    logic [31:0] rdData;
    logic [1:0] rdResp;
    logic [7:0] regIdx [10] = '{IDX_MAIN_CONTROL, IDX_MEASURE_TRIGGER, IDX_WINDOW_CONFIG, IDX_IRQ_ENABLE_CLEAR,
        IDX_IRQ_ENABLE_SET, IDX_IRQ_FLAGS, IDX_METER_STATE, IDX_SYNC_PENDING, IDX_COUNT_RESULT, 8'h05};

    fm_frequency_meter fm_frequency_meter_i (.mclk(mclk), .reset(reset), .axiReq(axiReq), .axiRsp(axiRsp),
        .measuredClock(measuredClock), .referenceClock(referenceClock), .accessProtect(accessProtect),
        .irqReq(irqReq));

    ////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // reference rises fall mid-way between measured rises
    always @(posedge mclk) begin
        phaseCnt <= (phaseCnt >= 8 * refMult - 1) ? 0 : phaseCnt + 1;
        referenceClock <= (phaseCnt < 4 * refMult);
        measuredClock <= phaseCnt[2];
    end

    ////////////////////////////////////////////////////////////
    function automatic logic [7:0] byteAddr(input logic [7:0] idx);
        return {idx[5:0], 2'b00};
    endfunction : byteAddr

    function automatic logic [31:0] expCount(input int n, input int k);
        return 32'(n * k);
    endfunction : expCount

    task automatic conclude;
        $display("checks %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : conclude

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic limitCheck(input int n, input int limit);
        if (n >= limit) begin
            mismatches++;
            $display("mismatch wait limit reached");
            conclude();
        end
    endtask : limitCheck

    task automatic axiWrite(input logic [7:0] addr, input logic [31:0] data);
        int n;
        n = 0;
        @(posedge mclk);
        axiReq.awvalid <= 1'b1;
        axiReq.awaddr <= addr;
        axiReq.wvalid <= 1'b1;
        axiReq.wdata <= data;
        axiReq.wstrb <= 4'hf;
        axiReq.bready <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
            if (axiReq.awvalid && axiRsp.awready) axiReq.awvalid <= 1'b0;
            if (axiReq.wvalid && axiRsp.wready) axiReq.wvalid <= 1'b0;
        end while (axiRsp.bvalid !== 1'b1 && n < 200);
        rdResp = axiRsp.bresp;
        axiReq.bready <= 1'b0;
        limitCheck(n, 200);
    endtask : axiWrite

    task automatic axiRead(input logic [7:0] addr);
        int n;
        n = 0;
        @(posedge mclk);
        axiReq.arvalid <= 1'b1;
        axiReq.araddr <= addr;
        axiReq.rready <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
            if (axiReq.arvalid && axiRsp.arready) axiReq.arvalid <= 1'b0;
        end while (axiRsp.rvalid !== 1'b1 && n < 200);
        rdData = axiRsp.rdata;
        rdResp = axiRsp.rresp;
        axiReq.rready <= 1'b0;
        limitCheck(n, 200);
    endtask : axiRead

    task automatic readCheck(input string what, input logic [7:0] idx, input logic [31:0] exp);
        axiRead(byteAddr(idx));
        check(what, rdData, exp);
    endtask : readCheck

    task automatic pollZero(input logic [7:0] idx, input logic [31:0] mask);
        int n;
        n = 0;
        do begin
            axiRead(byteAddr(idx));
            n++;
        end while ((rdData & mask) !== 32'h0 && n < 3000);
        limitCheck(n, 3000);
    endtask : pollZero

    ////////////////////////////////////////////////////////////
    initial begin
        seed = 32'h11077cd5;
        mismatches = 0;
        comparisons = 0;
        phaseCnt = 0;
        refMult = 2;
        reference_cycle_count = 1;
        axiReq = '0;
        reset = 1'b1;
        accessProtect = 1'b0;
        measuredClock = 1'b0;
        referenceClock = 1'b0;
        repeat (4) @(posedge mclk);
        reset <= 1'b0;
        foreach (regIdx[i]) readCheck("reset value", regIdx[i], 32'h0);
        axiWrite(8'h14, $random(seed));
        readCheck("reserved", 8'h05, 32'h0);
        axiWrite(byteAddr(IDX_MEASURE_TRIGGER), 32'h1);
        readCheck("busy while disabled", IDX_METER_STATE, 32'h0);
        readCheck("result while disabled", IDX_COUNT_RESULT, 32'h0);
        for (int it = 0; it < 5; it++) begin
            reference_cycle_count = (it == 0) ? 255 : (it == 1) ? 1 : 1 + $unsigned($random(seed)) % 8;
            refMult <= (it == 0) ? 2 : 2 + $unsigned($random(seed)) % 3;
            axiWrite(byteAddr(IDX_MAIN_CONTROL), 32'h0);
            pollZero(IDX_SYNC_PENDING, 32'h2);
            axiWrite(byteAddr(IDX_WINDOW_CONFIG), 32'(reference_cycle_count));
            axiWrite(byteAddr(IDX_MAIN_CONTROL), 32'h2);
            pollZero(IDX_SYNC_PENDING, 32'h2);
            readCheck("enable readback", IDX_MAIN_CONTROL, 32'h2);
            axiWrite(byteAddr(IDX_WINDOW_CONFIG), 32'(reference_cycle_count) ^ 32'h5a);
            readCheck("config while enabled", IDX_WINDOW_CONFIG, 32'(reference_cycle_count));
            axiWrite(byteAddr(IDX_IRQ_ENABLE_SET), 32'h1);
            readCheck("irq enable", IDX_IRQ_ENABLE_SET, 32'h1);
            axiWrite(byteAddr(IDX_MEASURE_TRIGGER), 32'h1);
            readCheck("busy", IDX_METER_STATE, 32'h1);
            pollZero(IDX_METER_STATE, 32'h1);
            readCheck("result", IDX_COUNT_RESULT, expCount(reference_cycle_count, refMult));
            readCheck("state after", IDX_METER_STATE, 32'h0);
            readCheck("done flag", IDX_IRQ_FLAGS, 32'h1);
            check("irq raised", 32'(irqReq), 32'h1);
            if (it % 2 == 1) begin
                axiWrite(byteAddr(IDX_IRQ_ENABLE_CLEAR), 32'h1);
                check("irq masked", 32'(irqReq), 32'h0);
                readCheck("flag kept", IDX_IRQ_FLAGS, 32'h1);
            end else begin
                axiWrite(byteAddr(IDX_IRQ_FLAGS), 32'h0);
                check("irq kept", 32'(irqReq), 32'h1);
                axiWrite(byteAddr(IDX_IRQ_FLAGS), 32'h1);
                check("irq cleared", 32'(irqReq), 32'h0);
            end
        end
        axiWrite(byteAddr(IDX_IRQ_ENABLE_SET), 32'h1);
        axiWrite(byteAddr(IDX_MEASURE_TRIGGER), 32'h1);
        pollZero(IDX_METER_STATE, 32'h1);
        check("irq before reset", 32'(irqReq), 32'h1);
        axiWrite(byteAddr(IDX_MAIN_CONTROL), 32'h0);
        pollZero(IDX_SYNC_PENDING, 32'h2);
        axiWrite(byteAddr(IDX_MAIN_CONTROL), 32'h3);
        readCheck("reset ongoing", IDX_MAIN_CONTROL, 32'h1);
        pollZero(IDX_SYNC_PENDING, 32'h1);
        check("irq after reset", 32'(irqReq), 32'h0);
        readCheck("reset over", IDX_MAIN_CONTROL, 32'h0);
        readCheck("config cleared", IDX_WINDOW_CONFIG, 32'h0);
        readCheck("irq enable cleared", IDX_IRQ_ENABLE_SET, 32'h0);
        readCheck("result cleared", IDX_COUNT_RESULT, 32'h0);
        readCheck("flag cleared", IDX_IRQ_FLAGS, 32'h0);
        accessProtect <= 1'b1;
        axiRead(byteAddr(IDX_MEASURE_TRIGGER));
        check("protected trigger read", 32'(rdResp), 32'(RESP_SLVERR));
        check("protected trigger data", rdData, 32'h0);
        axiRead(byteAddr(IDX_MAIN_CONTROL));
        check("protected control read", 32'(rdResp), 32'(RESP_OKAY));
        accessProtect <= 1'b0;
        conclude();
    end
endmodule : testbench

`default_nettype wire
